/* fetn_regs.svh */
// Purpose: Named constants for the transmit nibble encoder.
// Assumes: Included by bare name from the package and the encoder.
// Notes:   Code-groups are five bits wide, most significant bit first.
`ifndef FETN_REGS_SVH
`define FETN_REGS_SVH

// ----------------------------------------------------------------
// Control code-groups
// ----------------------------------------------------------------
`define FETN_CG_IDLE   5'h1f
`define FETN_CG_SSD1   5'h18
`define FETN_CG_SSD2   5'h11
`define FETN_CG_ESD1   5'h0d
`define FETN_CG_ESD2   5'h07
`define FETN_CG_TXERR  5'h04

// ----------------------------------------------------------------
// Data code-groups
// ----------------------------------------------------------------
`define FETN_CG_D0     5'h1e
`define FETN_CG_D1     5'h09
`define FETN_CG_D2     5'h14
`define FETN_CG_D3     5'h15
`define FETN_CG_D4     5'h0a
`define FETN_CG_D5     5'h0b
`define FETN_CG_D6     5'h0e
`define FETN_CG_D7     5'h0f
`define FETN_CG_D8     5'h12
`define FETN_CG_D9     5'h13
`define FETN_CG_DA     5'h16
`define FETN_CG_DB     5'h17
`define FETN_CG_DC     5'h1a
`define FETN_CG_DD     5'h1b
`define FETN_CG_DE     5'h1c
`define FETN_CG_DF     5'h1d

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define FETN_DIBIT_LO  1:0
`define FETN_DIBIT_HI  3:2
`define FETN_PHASE_LO  1'h0
`define FETN_PHASE_HI  1'h1
`define FETN_NIB_RST   4'h0

`endif

/* fetn_pkg.sv */
// Purpose: Types shared by the transmit nibble encoder.
// Assumes: fetn_regs.svh holds the constants.
// Notes:   None.
`include "fetn_regs.svh"

package fetn_pkg;

    // ------------------------------------------------------------
    // Encoder states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FETN_ST_IDLE = 2'b00,
        FETN_ST_SSD2 = 2'b01,
        FETN_ST_DATA = 2'b10,
        FETN_ST_ESD2 = 2'b11
    } fetn_state_t;

    // ------------------------------------------------------------
    // One captured nibble with its qualifiers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       txen;
        logic       txer;
        logic [3:0] nib;
    } fetn_nib_t;

endpackage : fetn_pkg

/* fetn_tx_encoder.sv */
// Purpose: MII/RMII transmit capture and 4B/5B encoder of a 10/100 PHY.
// Assumes: TX_CLK and REF_CLK are far slower than CLK_SYS; all pins are
//          asynchronous and, all but RESET, pass two flip-flops before use.
// Notes:   One code-group leaves per captured nibble, as a CODE_VALID pulse.
`timescale 1ns/100ps
`default_nettype none
`include "fetn_regs.svh"

module fetn_tx_encoder
    import fetn_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RESET,
    input  wire logic       RMII_MODE,
    input  wire logic       TX_CLK,
    input  wire logic       REF_CLK,
    input  wire logic       TX_EN,
    input  wire logic       TX_ER,
    input  wire logic [3:0] TXD,
    output logic      [4:0] CODE,
    output logic            CODE_VALID
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Clock and data share the same two stages so that they stay aligned;
    // a third stage on the clock only serves the edge detector.
    logic [8:0] meta_q;
    logic [8:0] sync_q;
    logic       clk_prev_q;
    logic       rmii_q;
    logic       link_clk;
    logic       clk_rise;

    always_ff @(posedge CLK_SYS) begin
        meta_q <= {RMII_MODE, TX_CLK, REF_CLK, TX_EN, TX_ER, TXD};
        sync_q <= meta_q;
        if (RESET) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= link_clk;
        end
    end

    assign rmii_q   = sync_q[8];
    assign link_clk = rmii_q ? sync_q[6] : sync_q[7];
    assign clk_rise = link_clk & ~clk_prev_q;

    logic       txen_s;
    logic       txer_s;
    logic [3:0] txd_s;

    assign txen_s = sync_q[5];
    assign txer_s = sync_q[4];
    assign txd_s  = sync_q[3:0];

    // ------------------------------------------------------------
    // Nibble capture and dibit pairing
    // ------------------------------------------------------------
    fetn_nib_t  nib_d;
    fetn_nib_t  nib_q;
    logic       nib_stb_d;
    logic       nib_stb_q;
    logic       phase_d;
    logic       phase_q;
    logic [1:0] lo_d;
    logic [1:0] lo_q;
    logic       en_prev_d;
    logic       en_prev_q;

    always_comb begin
        nib_d     = nib_q;
        nib_stb_d = 1'b0;
        phase_d   = phase_q;
        lo_d      = lo_q;
        en_prev_d = en_prev_q;
        if (clk_rise) begin
            if (!rmii_q) begin
                nib_d     = '{txen: txen_s, txer: txer_s, nib: txd_s};
                nib_stb_d = 1'b1;
            end else begin
                en_prev_d = txen_s;
                // A frame start realigns pairing so its first dibit is low.
                if ((txen_s && !en_prev_q) || phase_q == `FETN_PHASE_LO) begin
                    lo_d    = txd_s[`FETN_DIBIT_LO];
                    phase_d = `FETN_PHASE_HI;
                end else begin
                    nib_d     = '{txen: txen_s, txer: txer_s,
                                  nib: {txd_s[`FETN_DIBIT_LO], lo_q}};
                    nib_stb_d = 1'b1;
                    phase_d   = `FETN_PHASE_LO;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            nib_q     <= '{txen: 1'b0, txer: 1'b0, nib: `FETN_NIB_RST};
            nib_stb_q <= 1'b0;
            phase_q   <= `FETN_PHASE_LO;
            lo_q      <= 2'h0;
            en_prev_q <= 1'b0;
        end else begin
            nib_q     <= nib_d;
            nib_stb_q <= nib_stb_d;
            phase_q   <= phase_d;
            lo_q      <= lo_d;
            en_prev_q <= en_prev_d;
        end
    end

    // ------------------------------------------------------------
    // 4B/5B encoder
    // ------------------------------------------------------------
    function automatic logic [4:0] fetn_data_cg(input logic [3:0] n);
        logic [4:0] cg;
        cg = `FETN_CG_D0;
        unique case (n)
            4'h0: cg = `FETN_CG_D0;
            4'h1: cg = `FETN_CG_D1;
            4'h2: cg = `FETN_CG_D2;
            4'h3: cg = `FETN_CG_D3;
            4'h4: cg = `FETN_CG_D4;
            4'h5: cg = `FETN_CG_D5;
            4'h6: cg = `FETN_CG_D6;
            4'h7: cg = `FETN_CG_D7;
            4'h8: cg = `FETN_CG_D8;
            4'h9: cg = `FETN_CG_D9;
            4'ha: cg = `FETN_CG_DA;
            4'hb: cg = `FETN_CG_DB;
            4'hc: cg = `FETN_CG_DC;
            4'hd: cg = `FETN_CG_DD;
            4'he: cg = `FETN_CG_DE;
            4'hf: cg = `FETN_CG_DF;
        endcase
        return cg;
    endfunction : fetn_data_cg

    fetn_state_t state_d;
    fetn_state_t state_q;
    logic [4:0]  code_d;
    logic [4:0]  code_q;
    logic        vld_d;
    logic        vld_q;
    // Code-group of the previous pulse, so each delimiter half is tied to its partner.
    logic [4:0]  last_cg_d;
    logic [4:0]  last_cg_q;

    // The nibbles that carry the delimiters are dropped; the MAC's preamble absorbs
    // the start pair and the idle gap the end pair, so frame data stays in step with the code-groups.
    always_comb begin
        state_d = state_q;
        code_d  = code_q;
        vld_d   = 1'b0;
        last_cg_d = vld_q ? code_q : last_cg_q;
        if (nib_stb_q) begin
            vld_d = 1'b1;
            unique case (state_q)
                FETN_ST_IDLE: begin
                    if (nib_q.txen) begin
                        code_d  = `FETN_CG_SSD1;
                        state_d = FETN_ST_SSD2;
                    end else begin
                        code_d  = `FETN_CG_IDLE;
                    end
                end
                FETN_ST_SSD2: begin
                    code_d  = `FETN_CG_SSD2;
                    state_d = FETN_ST_DATA;
                end
                FETN_ST_DATA: begin
                    if (!nib_q.txen) begin
                        code_d  = `FETN_CG_ESD1;
                        state_d = FETN_ST_ESD2;
                    end else if (nib_q.txer) begin
                        code_d  = `FETN_CG_TXERR;
                    end else begin
                        code_d  = fetn_data_cg(nib_q.nib);
                    end
                end
                FETN_ST_ESD2: begin
                    code_d  = `FETN_CG_ESD2;
                    state_d = FETN_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_q <= FETN_ST_IDLE;
            code_q  <= `FETN_CG_IDLE;
            vld_q   <= 1'b0;
            last_cg_q <= `FETN_CG_IDLE;
        end else begin
            state_q <= state_d;
            code_q  <= code_d;
            vld_q   <= vld_d;
            last_cg_q <= last_cg_d;
        end
    end

    assign CODE       = code_q;
    assign CODE_VALID = vld_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_mii_capture;
        @(posedge CLK_SYS) disable iff (RESET)
        (clk_rise && !rmii_q) |=> nib_stb_q && nib_q.nib == $past(txd_s) && nib_q.txen == $past(txen_s);
    endproperty
    a_mii_capture: assert property (p_mii_capture) else $error("MII nibble not captured");

    property p_rmii_pair;
        @(posedge CLK_SYS) disable iff (RESET)
        (clk_rise && rmii_q && phase_q && !(txen_s && !en_prev_q)) |=> nib_stb_q && !phase_q;
    endproperty
    a_rmii_pair: assert property (p_rmii_pair) else $error("RMII second dibit gave no nibble");

    property p_rmii_order;
        @(posedge CLK_SYS) disable iff (RESET)
        (nib_stb_q && rmii_q) |-> nib_q.nib[1:0] == $past(lo_q) && nib_q.nib[3:2] == $past(txd_s[1:0]);
    endproperty
    a_rmii_order: assert property (p_rmii_order) else $error("RMII dibit order wrong");

    property p_data_enc;
        @(posedge CLK_SYS) disable iff (RESET)
        (nib_stb_q && state_q == FETN_ST_DATA && nib_q.txen && !nib_q.txer)
            |=> vld_q && code_q == fetn_data_cg($past(nib_q.nib));
    endproperty
    a_data_enc: assert property (p_data_enc) else $error("Data nibble encoded wrongly");

    property p_data_distinct;
        @(posedge CLK_SYS) disable iff (RESET)
        (nib_stb_q && state_q == FETN_ST_DATA && nib_q.txen && !nib_q.txer)
            |=> code_q != `FETN_CG_IDLE && code_q != `FETN_CG_SSD1 && code_q != `FETN_CG_TXERR;
    endproperty
    a_data_distinct: assert property (p_data_distinct) else $error("Data used control code");

    property p_txerr;
        @(posedge CLK_SYS) disable iff (RESET)
        (nib_stb_q && state_q == FETN_ST_DATA && nib_q.txen && nib_q.txer) |=> code_q == `FETN_CG_TXERR;
    endproperty
    a_txerr: assert property (p_txerr) else $error("Error code-group missing");

    property p_ssd;
        @(posedge CLK_SYS) disable iff (RESET)
        (vld_q && last_cg_q == `FETN_CG_SSD1) |-> code_q == `FETN_CG_SSD2;
    endproperty
    a_ssd: assert property (p_ssd) else $error("Start delimiter wrong");

    property p_esd;
        @(posedge CLK_SYS) disable iff (RESET)
        (nib_stb_q && state_q == FETN_ST_DATA && !nib_q.txen) |=> vld_q && code_q == `FETN_CG_ESD1;
    endproperty
    a_esd: assert property (p_esd) else $error("End delimiter wrong");

    property p_esd_pair;
        @(posedge CLK_SYS) disable iff (RESET)
        (vld_q && last_cg_q == `FETN_CG_ESD1) |-> code_q == `FETN_CG_ESD2;
    endproperty
    a_esd_pair: assert property (p_esd_pair) else $error("End delimiter second half wrong");

    property p_idle;
        @(posedge CLK_SYS) disable iff (RESET)
        (nib_stb_q && state_q == FETN_ST_IDLE && !nib_q.txen) |=> vld_q && code_q == `FETN_CG_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("Idle code-group missing");

endmodule : fetn_tx_encoder
`default_nettype wire

/* fetn_mac_model.sv */
// Purpose: Behavioural MAC that drives the MII or RMII transmit pins.
// Assumes: Pins change on the falling CLK_SYS edge; link clocks stand still between nibbles.
// Notes:   One link clock period is 10 CLK_SYS cycles (80 ns).
`timescale 1ns/100ps
`default_nettype none

module fetn_mac_model (
    input  wire logic       CLK_SYS,
    input  wire logic       RMII_MODE,
    output logic            TX_CLK,
    output logic            REF_CLK,
    output logic            TX_EN,
    output logic            TX_ER,
    output logic [3:0]      TXD
);
    initial begin
        TX_CLK  = 1'b0;
        REF_CLK = 1'b0;
        TX_EN   = 1'b0;
        TX_ER   = 1'b0;
        TXD     = 4'h0;
    end

    task automatic pulse(input logic rmii);
        repeat (5) @(negedge CLK_SYS);
        if (rmii) REF_CLK = 1'b1;
        else TX_CLK = 1'b1;
        repeat (5) @(negedge CLK_SYS);
        REF_CLK = 1'b0;
        TX_CLK  = 1'b0;
    endtask : pulse

    // Enable and error stay put over the whole nibble, both dibits in RMII.
    // The unused upper lines carry the inverse, so a wrong lane choice shows.
    task automatic send(input logic en, input logic er, input logic [3:0] nib);
        TX_EN = en;
        TX_ER = er;
        if (RMII_MODE) begin
            TXD = {~nib[1:0], nib[1:0]};
            pulse(1'b1);
            TXD = {~nib[3:2], nib[3:2]};
            pulse(1'b1);
        end else begin
            TXD = nib;
            pulse(1'b0);
        end
    endtask : send
endmodule : fetn_mac_model

`default_nettype wire

/* fetn_tx_encoder_tb_top.sv */
// Purpose: Self-checking bench for the transmit nibble encoder.
// Assumes: Inputs change on the falling CLK_SYS edge.
// Notes:   Code-groups are collected at each CODE_VALID pulse and compared in order.
`timescale 1ns/100ps
`default_nettype none

module fetn_tx_encoder_tb_top;
    logic       CLK_SYS, RESET, RMII_MODE, TX_CLK, REF_CLK, TX_EN, TX_ER, CODE_VALID;
    logic [3:0] TXD;
    logic [4:0] CODE;
    logic [4:0] got_q[$];
    logic [4:0] exp_q[$];
    int         fails = 0;
    int         checked = 0;
    localparam logic [4:0] DATA_CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    initial CLK_SYS = 1'b0;
    always #4 CLK_SYS = ~CLK_SYS;

    fetn_tx_encoder fetn_tx_encoder_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .RMII_MODE(RMII_MODE),
        .TX_CLK(TX_CLK), .REF_CLK(REF_CLK), .TX_EN(TX_EN), .TX_ER(TX_ER), .TXD(TXD),
        .CODE(CODE), .CODE_VALID(CODE_VALID));
    fetn_mac_model fetn_mac_model_i (.CLK_SYS(CLK_SYS), .RMII_MODE(RMII_MODE), .TX_CLK(TX_CLK),
        .REF_CLK(REF_CLK), .TX_EN(TX_EN), .TX_ER(TX_ER), .TXD(TXD));

    always @(negedge CLK_SYS) if (CODE_VALID === 1'b1) got_q.push_back(CODE);

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : check

    task automatic end_of_test;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic nib(input logic en, input logic er, input logic [3:0] n, input logic [4:0] cg);
        fetn_mac_model_i.send(en, er, n);
        exp_q.push_back(cg);
    endtask : nib

    // Two preamble nibbles become the start pair; the two after the frame become the end pair.
    task automatic frame(input logic [3:0] base, input int n, input int er_at);
        logic [3:0] d;
        nib(1'b1, 1'b0, 4'h5, 5'h18);
        nib(1'b1, 1'b0, 4'h5, 5'h11);
        for (int i = 0; i < n; i++) begin
            d = base + 4'(i);
            nib(1'b1, i == er_at, d, (i == er_at) ? 5'h04 : DATA_CG[d]);
        end
        nib(1'b0, 1'b0, 4'h3, 5'h0d);
        nib(1'b0, 1'b0, 4'hc, 5'h07);
    endtask : frame

    task automatic compare_stream(input logic strip);
        repeat (8) @(negedge CLK_SYS);
        while (strip && got_q.size() > 0 && got_q[0] === 5'h1f) got_q.pop_front();
        check(8'(got_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) if (i < got_q.size()) check({3'h0, got_q[i]}, {3'h0, exp_q[i]});
        got_q.delete();
        exp_q.delete();
    endtask : compare_stream

    task automatic t_reset;
        @(negedge CLK_SYS);
        check({3'h0, CODE}, 8'h1f);
        RESET = 1'b0;
        repeat (5) @(negedge CLK_SYS);
        check({2'h0, CODE_VALID, CODE}, 8'h1f);
        check(8'(got_q.size()), 8'h00);
    endtask : t_reset

    task automatic t_mii_all;
        nib(1'b0, 1'b0, 4'ha, 5'h1f);
        nib(1'b0, 1'b0, 4'h5, 5'h1f);
        frame(4'h0, 16, -1);
        nib(1'b0, 1'b0, 4'hf, 5'h1f);
        nib(1'b0, 1'b0, 4'h0, 5'h1f);
        compare_stream(1'b0);
    endtask : t_mii_all

    task automatic t_mii_err_b2b;
        frame(4'h9, 3, 1);
        frame(4'he, 2, -1);
        nib(1'b0, 1'b0, 4'h7, 5'h1f);
        compare_stream(1'b0);
    endtask : t_mii_err_b2b

    task automatic t_rmii;
        RMII_MODE = 1'b1;
        repeat (6) @(negedge CLK_SYS);
        fetn_mac_model_i.send(1'b0, 1'b0, 4'h0);
        repeat (8) @(negedge CLK_SYS);
        got_q.delete();
        frame(4'h6, 3, 2);
        nib(1'b0, 1'b0, 4'h0, 5'h1f);
        compare_stream(1'b1);
    endtask : t_rmii

    initial begin
        RESET     = 1'b1;
        RMII_MODE = 1'b0;
        repeat (5) @(posedge CLK_SYS);
        t_reset();
        t_mii_all();
        t_mii_err_b2b();
        t_rmii();
        end_of_test();
    end

    // The tests need well under 3000 cycles.
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        fails++;
        end_of_test();
    end
endmodule : fetn_tx_encoder_tb_top

`default_nettype wire
